// File: hdl/speed_cmd_pkg.sv
// Constants, register map and function codes for the speed command block
package speed_cmd_pkg;
    // Timing
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned CTRL_PERIOD_US  = 125;
    localparam int unsigned CTRL_CYCLES     = CLK_HZ / 1_000_000 * CTRL_PERIOD_US;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;

    // Register byte offsets
    localparam logic [7:0] ADDR_UP_TIME     = 8'h00;
    localparam logic [7:0] ADDR_DOWN_TIME   = 8'h04;
    localparam logic [7:0] ADDR_CLAMP_THR   = 8'h08;
    localparam logic [7:0] ADDR_TURN_THR    = 8'h0C;
    localparam logic [7:0] ADDR_MATCH_THR   = 8'h10;
    localparam logic [7:0] ADDR_CTRL        = 8'h14;
    localparam logic [7:0] ADDR_SEG_SRC     = 8'h18;
    localparam logic [7:0] ADDR_SEG_SPD0    = 8'h1C;
    localparam logic [7:0] ADDR_IN_MAP      = 8'h2C;
    localparam logic [7:0] ADDR_OUT_MAP     = 8'h30;
    localparam logic [7:0] ADDR_MAX_SPEED   = 8'h34;
    localparam logic [7:0] ADDR_STATUS      = 8'h38;
    localparam logic [7:0] ADDR_SPEED_REF   = 8'h3C;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h40;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h44;

    // Control register fields
    localparam int unsigned CTRL_EN_BIT     = 0;
    localparam int unsigned CTRL_SRC_LSB    = 4;

    // Reset values and limits
    localparam logic [15:0] RAMP_TIME_RST   = 16'h00C8;
    localparam logic [15:0] RAMP_TIME_MAX   = 16'h2710;
    localparam logic [15:0] CLAMP_THR_RST   = 16'h000A;
    localparam logic [15:0] TURN_THR_RST    = 16'h0014;
    localparam logic [15:0] SPEED_THR_MAX   = 16'h2710;
    localparam logic [15:0] MATCH_THR_RST   = 16'h000A;
    localparam logic [15:0] MATCH_THR_MAX   = 16'h0064;
    localparam logic [15:0] MAX_SPEED_RST   = 16'h0BB8;
    localparam logic [31:0] IN_MAP_RST      = 32'h0A09080C;
    localparam logic [15:0] OUT_MAP_RST     = 16'h0403;

    // Speed sources
    localparam logic [2:0] SRC_SINGLE       = 3'h0;
    localparam logic [2:0] SRC_MIXED        = 3'h4;
    localparam logic [3:0] SEG_SRC_INTERNAL = 4'h0;

    // Switch function codes
    localparam logic [7:0] FN_SPEED_MATCH   = 8'h03;
    localparam logic [7:0] FN_TURNING       = 8'h04;
    localparam logic [7:0] FN_DIRECTION     = 8'h08;
    localparam logic [7:0] FN_SEL_LO        = 8'h09;
    localparam logic [7:0] FN_SEL_HI        = 8'h0A;
    localparam logic [7:0] FN_SHAFT_LOCK    = 8'h0C;

    // Interrupt status bits
    localparam int unsigned IRQ_TURNING     = 0;
    localparam int unsigned IRQ_MATCH       = 1;
    localparam int unsigned IRQ_LOCK        = 2;
    localparam int unsigned IRQ_W           = 3;
endpackage : speed_cmd_pkg

// File: hdl/speed_cmd.sv
// Speed command conditioning, shaft lock and speed status outputs with APB registers
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
module speed_cmd
    import speed_cmd_pkg::*;
#(
    parameter int unsigned IN_TERMS = 4
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Switch terminals
    input  wire logic [IN_TERMS-1:0] switch_in,
    output logic      [1:0]          switch_out,
    // Motor feedback
    input  wire logic signed [15:0]  fb_speed,
    input  wire logic signed [31:0]  enc_pos,
    // Drive side
    output logic signed [15:0]       speed_ref,
    output logic                     shaft_locked,
    output logic                     irq
);

    typedef struct packed {
        logic [IN_TERMS-1:0]        s1;
        logic [IN_TERMS-1:0]        s2;
        logic [IN_TERMS-1:0]        s3;
        logic [IN_TERMS-1:0]        swq;
        logic [15:0]                up_time;
        logic [15:0]                down_time;
        logic [15:0]                clamp_thr;
        logic [15:0]                turn_thr;
        logic [15:0]                match_thr;
        logic [15:0]                max_speed;
        logic                       en;
        logic [2:0]                 src;
        logic [15:0]                seg_src;
        logic [3:0][15:0]           seg_spd;
        logic [IN_TERMS-1:0][7:0]   in_map;
        logic [1:0][7:0]            out_map;
        logic [IRQ_W-1:0]           irq_st;
        logic [IRQ_W-1:0]           irq_mask;
        logic [11:0]                tick_cnt;
        logic [15:0]                ramp_ref;
        logic [15:0]                target;
        logic [31:0]                acc;
        logic                       locked;
        logic [31:0]                lock_pos;
        logic                       turning;
        logic                       matching;
        logic [1:0]                 sw_out;
        logic [15:0]                speed_out;
        logic                       pready;
        logic                       pslverr;
        logic [31:0]                prdata;
        logic                       irq;
    } state_t;

    state_t st_reg;
    state_t st_next;

    function automatic state_t reset_state();
        state_t s;
        s           = '0;
        s.up_time   = RAMP_TIME_RST;
        s.down_time = RAMP_TIME_RST;
        s.clamp_thr = CLAMP_THR_RST;
        s.turn_thr  = TURN_THR_RST;
        s.match_thr = MATCH_THR_RST;
        s.max_speed = MAX_SPEED_RST;
        s.in_map    = IN_MAP_RST[IN_TERMS*8-1:0];
        s.out_map   = OUT_MAP_RST;
        return s;
    endfunction : reset_state

    // True when some terminal carries the code and reads high
    function automatic logic fn_active(input logic [IN_TERMS-1:0][7:0] map,
                                       input logic [IN_TERMS-1:0]      lvl,
                                       input logic [7:0]               code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < IN_TERMS; i++) begin
            if (map[i] == code && lvl[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : fn_active

    function automatic logic [15:0] limit16(input logic [31:0] v, input logic [15:0] lim);
        return (v[31:16] != 16'h0000 || v[15:0] > lim) ? lim : v[15:0];
    endfunction : limit16

    function automatic logic [16:0] abs17(input logic signed [16:0] v);
        return v[16] ? 17'(-v) : v;
    endfunction : abs17

    function automatic logic is_mapped(input logic [7:0] a);
        return a[1:0] == 2'b00 && a <= ADDR_IRQ_MASK;
    endfunction : is_mapped

    localparam logic [11:0] TICK_LAST = 12'(CTRL_CYCLES - 1);

    logic                dir_in;
    logic                sel_lo;
    logic                sel_hi;
    logic                lock_req;
    logic [1:0]          seg_idx;
    logic [3:0]          seg_field;
    logic signed [15:0]  cmd;
    logic [16:0]         cmd_mag;
    logic                lock_cond;
    logic                rising;
    logic                away;
    logic [15:0]         ramp_time;
    logic [31:0]         step_lim;
    logic [31:0]         acc_sum;
    logic signed [31:0]  pos_err;
    logic signed [15:0]  loop_out;
    logic [16:0]         fb_mag;
    logic [16:0]         dev_mag;
    logic                tick;
    logic                acc_ph;
    logic                wr_en;
    logic [31:0]         rd_val;
    logic [IRQ_W-1:0]    irq_ev;

    always_comb begin
        st_next   = st_reg;
        dir_in    = 1'b0;
        sel_lo    = 1'b0;
        sel_hi    = 1'b0;
        lock_req  = 1'b0;
        seg_idx   = 2'd0;
        seg_field = 4'h0;
        cmd       = '0;
        cmd_mag   = '0;
        lock_cond = 1'b0;
        rising    = 1'b0;
        away      = 1'b0;
        ramp_time = '0;
        step_lim  = '0;
        acc_sum   = '0;
        pos_err   = '0;
        loop_out  = '0;
        fb_mag    = '0;
        dev_mag   = '0;
        irq_ev    = '0;
        rd_val    = '0;

        // Pin synchronisers; a level is taken once stages two and three agree
        st_next.s1 = switch_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < IN_TERMS; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.swq[i] = st_reg.s3[i];
            end
        end

        // Control cycle divider
        tick = (st_reg.tick_cnt == TICK_LAST);
        st_next.tick_cnt = tick ? 12'd0 : st_reg.tick_cnt + 12'd1;

        // Terminal decode by function code
        dir_in   = fn_active(st_reg.in_map, st_reg.swq, FN_DIRECTION);
        sel_lo   = fn_active(st_reg.in_map, st_reg.swq, FN_SEL_LO);
        sel_hi   = fn_active(st_reg.in_map, st_reg.swq, FN_SEL_HI);
        lock_req = fn_active(st_reg.in_map, st_reg.swq, FN_SHAFT_LOCK);

        // Command source selection
        if (st_reg.src == SRC_MIXED) begin
            seg_idx   = {sel_hi, sel_lo};
            seg_field = st_reg.seg_src[seg_idx*4 +: 4];
            if (seg_field == SEG_SRC_INTERNAL) begin
                cmd = $signed(st_reg.seg_spd[seg_idx]);
            end
            if (dir_in) begin
                cmd = 16'(-cmd);
            end
        end else if (st_reg.src == SRC_SINGLE) begin
            cmd = $signed(st_reg.seg_spd[0]);
        end
        // Disabled drive follows nothing
        if (!st_reg.en) begin
            cmd = '0;
        end
        cmd_mag   = abs17(17'(cmd));
        lock_cond = st_reg.en && lock_req && (cmd_mag < {1'b0, st_reg.clamp_thr});
        st_next.target = cmd;

        // Lock entry latches the position to hold
        st_next.locked = lock_cond;
        if (lock_cond && !st_reg.locked) begin
            st_next.lock_pos = enc_pos;
            irq_ev[IRQ_LOCK] = 1'b1;
        end

        // Ramp generator: Bresenham on max speed over ramp time, one rpm per step
        rising    = $signed(st_reg.target) > $signed(st_reg.ramp_ref);
        away      = rising ? !st_reg.ramp_ref[15] : (st_reg.ramp_ref[15] || st_reg.ramp_ref == '0);
        ramp_time = away ? st_reg.up_time : st_reg.down_time;
        step_lim  = 32'(ramp_time) * 32'(CYC_PER_MS);
        acc_sum   = st_reg.acc + 32'(st_reg.max_speed);
        if (!st_reg.en || st_reg.locked) begin
            // Command ignored; restart ramp from standstill on release
            st_next.ramp_ref = '0;
            st_next.acc      = '0;
        end else if (st_reg.ramp_ref == st_reg.target) begin
            st_next.acc = '0;
        end else if (ramp_time == '0) begin
            st_next.ramp_ref = st_reg.target;
            st_next.acc      = '0;
        end else if (acc_sum >= step_lim) begin
            st_next.acc      = acc_sum - step_lim;
            st_next.ramp_ref = rising ? st_reg.ramp_ref + 16'd1 : st_reg.ramp_ref - 16'd1;
        end else begin
            st_next.acc = acc_sum;
        end

        // Position loop with a one-pulse dead band, gain one rpm per pulse
        pos_err = $signed(st_reg.lock_pos) - enc_pos;
        if (pos_err > 32'sd1 || pos_err < -32'sd1) begin
            if (pos_err > $signed({16'h0000, st_reg.max_speed})) begin
                loop_out = $signed(st_reg.max_speed);
            end else if (pos_err < -$signed({16'h0000, st_reg.max_speed})) begin
                loop_out = 16'(-$signed(st_reg.max_speed));
            end else begin
                loop_out = pos_err[15:0];
            end
        end
        st_next.speed_out = st_reg.locked ? loop_out : st_reg.ramp_ref;

        // Status flags, refreshed once per control cycle
        fb_mag  = abs17(17'(fb_speed));
        dev_mag = abs17(17'($signed(fb_speed)) - 17'($signed(st_reg.target)));
        if (tick) begin
            st_next.turning  = fb_mag > {1'b0, st_reg.turn_thr};
            st_next.matching = dev_mag <= {1'b0, st_reg.match_thr};
        end
        irq_ev[IRQ_TURNING] = st_next.turning && !st_reg.turning;
        irq_ev[IRQ_MATCH]   = st_next.matching && !st_reg.matching;

        // Output terminals by function code
        for (int k = 0; k < 2; k++) begin
            case (st_reg.out_map[k])
                FN_SPEED_MATCH: st_next.sw_out[k] = st_reg.matching;
                FN_TURNING:     st_next.sw_out[k] = st_reg.turning;
                default:        st_next.sw_out[k] = 1'b0;
            endcase
        end

        // APB: one wait state, write and read take effect with pready
        acc_ph = psel && penable;
        wr_en  = acc_ph && st_reg.pready && pwrite && is_mapped(paddr);
        st_next.pready = acc_ph && !st_reg.pready;
        case (paddr)
            ADDR_UP_TIME:    rd_val = {16'h0000, st_reg.up_time};
            ADDR_DOWN_TIME:  rd_val = {16'h0000, st_reg.down_time};
            ADDR_CLAMP_THR:  rd_val = {16'h0000, st_reg.clamp_thr};
            ADDR_TURN_THR:   rd_val = {16'h0000, st_reg.turn_thr};
            ADDR_MATCH_THR:  rd_val = {16'h0000, st_reg.match_thr};
            ADDR_CTRL:       rd_val = {25'h0, st_reg.src, 3'h0, st_reg.en};
            ADDR_SEG_SRC:    rd_val = {16'h0000, st_reg.seg_src};
            ADDR_IN_MAP:     rd_val = 32'(st_reg.in_map);
            ADDR_OUT_MAP:    rd_val = {16'h0000, st_reg.out_map};
            ADDR_MAX_SPEED:  rd_val = {16'h0000, st_reg.max_speed};
            ADDR_STATUS:     rd_val = {28'h0, st_reg.swq == '0, st_reg.locked,
                                       st_reg.matching, st_reg.turning};
            ADDR_SPEED_REF:  rd_val = {{16{st_reg.speed_out[15]}}, st_reg.speed_out};
            ADDR_IRQ_STATUS: rd_val = 32'(st_reg.irq_st);
            ADDR_IRQ_MASK:   rd_val = 32'(st_reg.irq_mask);
            default: begin
                rd_val = '0;
                for (int j = 0; j < 4; j++) begin
                    if (paddr == ADDR_SEG_SPD0 + 8'(4 * j)) begin
                        rd_val = {16'h0000, st_reg.seg_spd[j]};
                    end
                end
            end
        endcase
        if (acc_ph && !st_reg.pready) begin
            st_next.prdata  = pwrite ? 32'h00000000 : rd_val;
            st_next.pslverr = !is_mapped(paddr);
        end

        // Time and threshold writes are clipped to their legal range
        if (wr_en) begin
            case (paddr)
                ADDR_UP_TIME:   st_next.up_time   = limit16(pwdata, RAMP_TIME_MAX);
                ADDR_DOWN_TIME: st_next.down_time = limit16(pwdata, RAMP_TIME_MAX);
                ADDR_CLAMP_THR: st_next.clamp_thr = limit16(pwdata, SPEED_THR_MAX);
                ADDR_TURN_THR:  st_next.turn_thr  = limit16(pwdata, SPEED_THR_MAX);
                ADDR_MATCH_THR: st_next.match_thr = limit16(pwdata, MATCH_THR_MAX);
                ADDR_CTRL: begin
                    st_next.en  = pwdata[CTRL_EN_BIT];
                    st_next.src = pwdata[CTRL_SRC_LSB +: 3];
                end
                ADDR_SEG_SRC:   st_next.seg_src   = pwdata[15:0];
                ADDR_IN_MAP:    st_next.in_map    = pwdata[IN_TERMS*8-1:0];
                ADDR_OUT_MAP:   st_next.out_map   = pwdata[15:0];
                ADDR_MAX_SPEED: st_next.max_speed = limit16(pwdata, SPEED_THR_MAX);
                ADDR_IRQ_MASK:  st_next.irq_mask  = pwdata[IRQ_W-1:0];
                default: begin
                    for (int j = 0; j < 4; j++) begin
                        if (paddr == ADDR_SEG_SPD0 + 8'(4 * j)) begin
                            st_next.seg_spd[j] = pwdata[15:0];
                        end
                    end
                end
            endcase
        end

        // Sticky events; a new event outranks a same-cycle write-one clear
        st_next.irq_st = st_reg.irq_st;
        if (wr_en && paddr == ADDR_IRQ_STATUS) begin
            st_next.irq_st = st_reg.irq_st & ~pwdata[IRQ_W-1:0];
        end
        st_next.irq_st = st_next.irq_st | irq_ev;
        st_next.irq    = |(st_next.irq_st & st_next.irq_mask);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_reg <= reset_state();
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata       = st_reg.prdata;
    assign pready       = st_reg.pready;
    assign pslverr      = st_reg.pslverr;
    assign switch_out   = st_reg.sw_out;
    assign speed_ref    = $signed(st_reg.speed_out);
    assign shaft_locked = st_reg.locked;
    assign irq          = st_reg.irq;

endmodule : speed_cmd

// File: bench/speed_cmd_sva.sv
// Port assertions for the speed command block
`timescale 1ns/1ps
module speed_cmd_sva
    import speed_cmd_pkg::*;
#(
    parameter int unsigned IN_TERMS = 4
) (
    // Clock and reset
    input wire logic                sys_clk,
    input wire logic                sys_rst,
    // APB
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // Terminals and drive side
    input wire logic [IN_TERMS-1:0] switch_in,
    input wire logic [1:0]          switch_out,
    input wire logic signed [15:0]  fb_speed,
    input wire logic signed [31:0]  enc_pos,
    input wire logic signed [15:0]  speed_ref,
    input wire logic                shaft_locked,
    input wire logic                irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held past one cycle");
    property p_ready_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("pready not on second access cycle");
    property p_err_decode; pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > ADDR_IRQ_MASK);
    endproperty
    a_err_decode: assert property (p_err_decode)
        else $error("pslverr does not match address decode");
    property p_err_data; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_err_data: assert property (p_err_data)
        else $error("refused read returned data");
    // Lock input sits on terminal 0 under the default input map
    property p_lock_entry; $rose(shaft_locked) |-> $past(switch_in[0], 2); endproperty
    a_lock_entry: assert property (p_lock_entry)
        else $error("lock entered without lock input");
    property p_lock_level; !switch_in[0] [*8] |-> !shaft_locked; endproperty
    a_lock_level: assert property (p_lock_level)
        else $error("lock held after lock input dropped");
    property p_lock_hold;
        $stable(enc_pos) [*4] ##0 $rose(shaft_locked) ##1 (shaft_locked && $stable(enc_pos)) [*2]
            |-> speed_ref == 16'sh0000;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("undisturbed lock drives nonzero reference");
    // Flags only move on the control tick, far apart
    property p_out_cadence; $changed(switch_out) |=> $stable(switch_out) [*8]; endproperty
    a_out_cadence: assert property (p_out_cadence)
        else $error("switch outputs changed between control ticks");
endmodule : speed_cmd_sva

// File: bench/host_ctrl_model.sv
// Host controller model driving the switch input terminals
`timescale 1ns/1ps
module host_ctrl_model (
    // Clock
    input  wire logic       sys_clk,
    // Requests from the bench
    input  wire logic       lock_req,
    input  wire logic       dir_req,
    input  wire logic [1:0] seg_req,
    // Terminals
    output logic      [3:0] switch_in,
    input  wire logic [1:0] switch_out,
    // Status seen by the host
    output logic            turning_seen,
    output logic            match_seen
);
    // Terminal order follows the default input map
    always @(posedge sys_clk) begin
        switch_in[0] <= lock_req;
        switch_in[1] <= dir_req;
        switch_in[2] <= seg_req[0];
        switch_in[3] <= seg_req[1];
    end
    assign match_seen   = switch_out[0];
    assign turning_seen = switch_out[1];
endmodule : host_ctrl_model

// File: bench/tb_speed_cmd.sv
// Self-checking bench for the speed command block
`timescale 1ns/1ps
module tb_speed_cmd;
    import speed_cmd_pkg::*;
    logic               sys_clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [3:0]         switch_in;
    logic [1:0]         switch_out;
    logic signed [15:0] fb_speed = 16'sh0000;
    logic signed [31:0] enc_pos = 32'sh0;
    logic signed [15:0] speed_ref;
    logic               shaft_locked;
    logic               irq;
    logic               lock_req = 1'b0;
    logic               dir_req = 1'b0;
    logic [1:0]         seg_req = 2'h0;
    logic               turning_seen;
    logic               match_seen;
    logic [31:0]        rd;
    logic               err;
    int                 fail_count = 0;
    int                 num_checks = 0;

    always #25 sys_clk = ~sys_clk;

    speed_cmd #(.IN_TERMS(4)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .switch_in(switch_in), .switch_out(switch_out),
        .fb_speed(fb_speed), .enc_pos(enc_pos), .speed_ref(speed_ref),
        .shaft_locked(shaft_locked), .irq(irq));
    host_ctrl_model host (
        .sys_clk(sys_clk), .lock_req(lock_req), .dir_req(dir_req), .seg_req(seg_req),
        .switch_in(switch_in), .switch_out(switch_out), .turning_seen(turning_seen),
        .match_seen(match_seen));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [31:0] sx(input logic signed [15:0] v);
        return 32'(v);
    endfunction : sx
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_clk
    // Request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for pready
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rd_chk

    task automatic t_regs;
        logic [7:0]  a [5] = '{ADDR_UP_TIME, ADDR_DOWN_TIME, ADDR_CLAMP_THR, ADDR_TURN_THR,
                               ADDR_MATCH_THR};
        logic [15:0] v [5] = '{16'h00C8, 16'h00C8, 16'h000A, 16'h0014, 16'h000A};
        for (int i = 0; i < 5; i++) rd_chk("reset value", a[i], {16'h0, v[i]});
        apb(1'b1, ADDR_UP_TIME, 32'h0000FFFF);
        rd_chk("up time clip", ADDR_UP_TIME, 32'h00002710);
        apb(1'b1, ADDR_MATCH_THR, 32'h000000C8);
        rd_chk("window clip", ADDR_MATCH_THR, 32'h00000064);
        apb(1'b1, ADDR_MATCH_THR, 32'h0000000A);
        apb(1'b0, 8'h4C, 32'h0);
        chk("unmapped refused", 32'h1, {31'h0, err});
    endtask : t_regs

    // Max speed 3000 rpm: 300 rpm takes 0.1 ms per ramp millisecond
    task automatic t_ramp;
        apb(1'b1, ADDR_SEG_SPD0, 32'h0000012C);
        apb(1'b1, ADDR_UP_TIME, 32'h1);
        apb(1'b1, ADDR_DOWN_TIME, 32'h2);
        wait_clk(100);
        chk("ref disabled", 32'h0, sx(speed_ref));
        apb(1'b1, ADDR_CTRL, 32'h1);
        wait_clk(1000);
        chk("ramp up mid", 32'h1, {31'h0, speed_ref > 16'sh008C && speed_ref < 16'sh00A0});
        wait_clk(1100);
        chk("ramp up end", 32'h0000012C, sx(speed_ref));
        apb(1'b1, ADDR_SEG_SPD0, 32'h0);
        wait_clk(2000);
        chk("ramp down mid", 32'h1, {31'h0, speed_ref > 16'sh008C && speed_ref < 16'sh00A0});
        wait_clk(2200);
        chk("ramp down end", 32'h0, sx(speed_ref));
        apb(1'b1, ADDR_UP_TIME, 32'h0);
        apb(1'b1, ADDR_DOWN_TIME, 32'h0);
        apb(1'b1, ADDR_SEG_SPD0, 32'hFFFFFED4);
        wait_clk(10);
        chk("reverse", 32'hFFFFFED4, sx(speed_ref));
    endtask : t_ramp

    task automatic t_mixed;
        apb(1'b1, ADDR_CTRL, 32'h41);
        for (int s = 0; s < 4; s++) apb(1'b1, ADDR_SEG_SPD0 + 8'(4 * s), 32'(100 * (s + 1)));
        apb(1'b1, ADDR_SEG_SRC, 32'h00001000);
        for (int s = 0; s < 4; s++) begin
            seg_req <= 2'(s);
            wait_clk(20);
            chk("segment", (s == 3) ? 32'h0 : 32'(100 * (s + 1)), sx(speed_ref));
        end
        seg_req <= 2'h1;
        dir_req <= 1'b1;
        wait_clk(20);
        chk("direction", 32'hFFFFFF38, sx(speed_ref));
        seg_req <= 2'h0;
        dir_req <= 1'b0;
    endtask : t_mixed

    task automatic t_lock;
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_SEG_SPD0, 32'h5);
        enc_pos <= 32'sh3E8;
        wait_clk(20);
        lock_req <= 1'b1;
        wait_clk(20);
        chk("locked", 32'h1, {31'h0, shaft_locked});
        chk("lock hold", 32'h0, sx(speed_ref));
        enc_pos <= 32'sh3EF;
        wait_clk(5);
        chk("push back", 32'hFFFFFFF9, sx(speed_ref));
        enc_pos <= 32'sh3E9;
        wait_clk(5);
        chk("one pulse band", 32'h0, sx(speed_ref));
        lock_req <= 1'b0;
        wait_clk(20);
        chk("released", 32'h0, {31'h0, shaft_locked});
        apb(1'b1, ADDR_SEG_SPD0, 32'h32);
        lock_req <= 1'b1;
        wait_clk(20);
        chk("lock refused", 32'h0, {31'h0, shaft_locked});
        chk("ref follows", 32'h32, sx(speed_ref));
        lock_req <= 1'b0;
    endtask : t_lock

    task automatic t_status;
        logic signed [15:0] fb [3] = '{16'shFE0C, 16'sh01FE, 16'sh0014};
        logic [1:0]         ex [3] = '{2'h2, 2'h3, 2'h0};
        apb(1'b1, ADDR_IRQ_STATUS, 32'h7);
        apb(1'b1, ADDR_SEG_SPD0, 32'h1F4);
        fb_speed <= 16'sh01F4;
        wait_clk(2600);
        chk("outputs", 32'h3, {30'h0, turning_seen, match_seen});
        // Match was already high from the idle ramp, so only turning rises here
        rd_chk("events", ADDR_IRQ_STATUS, 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        wait_clk(3);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
        wait_clk(3);
        chk("irq cleared", 32'h0, {31'h0, irq});
        for (int i = 0; i < 3; i++) begin
            fb_speed <= fb[i];
            wait_clk(2600);
            chk("outputs", {30'h0, ex[i]}, {30'h0, turning_seen, match_seen});
        end
        rd_chk("match event", ADDR_IRQ_STATUS, 32'h2);
    endtask : t_status

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test

    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_ramp();
        t_mixed();
        t_lock();
        t_status();
        finish_test();
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        fail_count++;
        finish_test();
    end
endmodule : tb_speed_cmd

bind speed_cmd speed_cmd_sva #(.IN_TERMS(IN_TERMS)) u_sva (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .switch_in(switch_in), .switch_out(switch_out),
    .fb_speed(fb_speed), .enc_pos(enc_pos), .speed_ref(speed_ref),
    .shaft_locked(shaft_locked), .irq(irq));
